// ---- src/opdec_params.svh ----
`ifndef OPDEC_PARAMS_SVH
`define OPDEC_PARAMS_SVH

// Avalon register word addresses
`define REG_CTRL        4'h0
`define REG_FLAGS       4'h1
`define REG_STATUS      4'h2
`define REG_EXT_ADDR    4'h3
`define REG_DIRECT      4'h4
`define REG_TARGET      4'h5
`define REG_INDEXED     4'h6
`define REG_OPERANDS    4'h7
`define REG_SRC_DST     4'h8
`define REG_FETCH       4'h9

// Flag field positions in the flags register
`define FLAG_C          0
`define FLAG_Z          1
`define FLAG_S          2
`define FLAG_V          3

// Condition field position in the jump opcode
`define COND_HI         7
`define COND_LO         4

// Opcodes handled by the byte sequencer
`define OPC_ADD_REGS    8'h04

// Escape nibble marking a working register address
`define ESC_NIBBLE      4'hE

// Reset values
`define RST_BYTE        8'h00
`define RST_WORD        16'h0000

// Depth and address width of the byte memory
`define MEM_DEPTH       16
`define MEM_AW          4

`endif

// ---- src/opdec_pkg.sv ----
package opdec_pkg;

	typedef enum logic [3:0] {
		SEL_FALSE, SEL_LT, SEL_LE, SEL_ULE, SEL_OV, SEL_MI, SEL_Z, SEL_C,
		SEL_TRUE, SEL_GE, SEL_GT, SEL_UGT, SEL_NOV, SEL_PL, SEL_NZ, SEL_NC
	} cond_sel_e;

	typedef enum {
		ST_IDLE, ST_SRC, ST_DST
	} seq_state_e;

	typedef logic [7:0] byte_t;

endpackage : opdec_pkg

// ---- src/opdec_ram.sv ----
`timescale 1ns/1ps
`include "opdec_params.svh"

module opdec_ram (
	input  wire logic               i_clk,     // System clock
	input  wire logic               i_we,      // Write enable
	input  wire logic [`MEM_AW-1:0] i_waddr,   // Write address
	input  wire logic [7:0]         i_wdata,   // Write data
	input  wire logic [`MEM_AW-1:0] i_raddr,   // Read address
	output logic      [7:0]         o_rdata    // Registered read data
);

	logic [7:0] mem [0:`MEM_DEPTH-1];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		o_rdata <= mem[i_raddr];
	end

endmodule : opdec_ram

// ---- src/cond_code_operand_decode.sv ----
`timescale 1ns/1ps
`include "opdec_params.svh"

module cond_code_operand_decode
	import opdec_pkg::*;
(
	input  wire logic        I_CLK_SYS,            // 40 MHz system clock
	input  wire logic        I_RST_N,              // Synchronous reset, active low
	input  wire logic [3:0]  I_AVS_ADDRESS,        // Register word address
	input  wire logic        I_AVS_READ,           // Read request
	input  wire logic        I_AVS_WRITE,          // Write request
	input  wire logic [31:0] I_AVS_WRITEDATA,      // Write data
	input  wire logic [3:0]  I_AVS_BYTEENABLE,     // Byte enables
	input  wire logic [7:0]  I_PROG_BYTE,          // Instruction byte from program memory
	input  wire logic        I_PROG_VALID,         // Instruction byte valid
	input  wire logic [15:0] I_NEXT_PC,            // Address of the following instruction
	output logic [31:0]      O_AVS_READDATA,       // Read data
	output logic             O_AVS_WAITREQUEST,    // Wait request
	output logic             O_BRANCH_TAKEN,       // Conditional jump taken
	output logic [15:0]      O_BRANCH_TARGET,      // Relative jump target
	output logic             O_SRC_WORKING,        // Source is a working register
	output logic [7:0]       O_SRC_ADDR,           // Source register address
	output logic             O_DST_WORKING,        // Destination is a working register
	output logic [7:0]       O_DST_ADDR,           // Destination register address
	output logic             O_OPERANDS_VALID      // Source and destination decoded
);

	////////////////////////////////////////////////////////////////////////////
	// Condition evaluation

	function automatic logic cond_true(input logic [3:0] sel, input logic [3:0] fl);
		logic c;
		logic z;
		logic s;
		logic v;
		logic lt;
		c  = fl[`FLAG_C];
		z  = fl[`FLAG_Z];
		s  = fl[`FLAG_S];
		v  = fl[`FLAG_V];
		lt = s ^ v;
		case (cond_sel_e'(sel))
			SEL_FALSE: cond_true = 1'b0;
			SEL_TRUE:  cond_true = 1'b1;
			SEL_OV:    cond_true = v;
			SEL_MI:    cond_true = s;
			SEL_Z:     cond_true = z;
			SEL_C:     cond_true = c;
			SEL_NOV:   cond_true = ~v;
			SEL_PL:    cond_true = ~s;
			SEL_NZ:    cond_true = ~z;
			SEL_NC:    cond_true = ~c;
			SEL_LT:    cond_true = lt;
			SEL_LE:    cond_true = z | lt;
			SEL_GE:    cond_true = ~lt;
			SEL_GT:    cond_true = ~(z | lt);
			SEL_ULE:   cond_true = c | z;
			SEL_UGT:   cond_true = ~c & ~z;
			default:  cond_true = 1'b0;
		endcase
	endfunction : cond_true

	// Splits an 8-bit register field into escape flag and address
	function automatic logic [8:0] reg_decode(input logic [7:0] f);
		if (f[7:4] == `ESC_NIBBLE) begin
			reg_decode = {1'b1, 4'h0, f[3:0]};
		end else begin
			reg_decode = {1'b0, f};
		end
	endfunction : reg_decode

	////////////////////////////////////////////////////////////////////////////
	// Registers

	logic [7:0]  ctrl_reg;      // [7:4] condition opcode, [0] strobe eval
	logic [3:0]  flags_reg;
	logic [11:0] ext_reg;
	logic [15:0] direct_reg;
	logic [7:0]  disp_reg;
	logic [7:0]  index_reg;
	logic [7:0]  base_reg;
	logic [7:0]  pair_reg;
	logic [3:0]  wpair_reg;
	logic [2:0]  bit_reg;
	logic        pol_reg;
	logic [7:0]  vector_reg;
	logic [7:0]  imm_reg;
	logic        pair_err_reg;
	logic        wait_reg;
	logic        eval_reg;

	logic [3:0]  cond_sel;
	logic        taken_now;
	logic        wr_acc;
	logic        rd_take;

	assign cond_sel  = ctrl_reg[`COND_HI:`COND_LO];
	assign taken_now = cond_true(cond_sel, flags_reg);
	assign wr_acc    = I_AVS_WRITE & wait_reg;
	assign rd_take   = I_AVS_READ & ~wait_reg;

	// One wait cycle for every access, then accept
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			wait_reg <= 1'b0;
		end else if ((I_AVS_READ | I_AVS_WRITE) && !wait_reg) begin
			wait_reg <= 1'b1;
		end else begin
			wait_reg <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_AVS_WAITREQUEST <= 1'b1;
		end else begin
			O_AVS_WAITREQUEST <= ~((I_AVS_READ | I_AVS_WRITE) & ~wait_reg);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			ctrl_reg   <= `RST_BYTE;
			flags_reg  <= 4'h0;
			ext_reg    <= 12'h000;
			direct_reg <= `RST_WORD;
			disp_reg   <= `RST_BYTE;
			index_reg  <= `RST_BYTE;
			base_reg   <= `RST_BYTE;
			pair_reg   <= `RST_BYTE;
			wpair_reg  <= 4'h0;
			bit_reg    <= 3'h0;
			pol_reg    <= 1'b0;
			vector_reg <= `RST_BYTE;
			imm_reg    <= `RST_BYTE;
		end else if (wr_acc) begin
			if (I_AVS_ADDRESS == `REG_CTRL && I_AVS_BYTEENABLE[0]) begin
				ctrl_reg <= I_AVS_WRITEDATA[7:0];
			end else if (I_AVS_ADDRESS == `REG_FLAGS && I_AVS_BYTEENABLE[0]) begin
				flags_reg <= I_AVS_WRITEDATA[3:0];
			end else if (I_AVS_ADDRESS == `REG_EXT_ADDR) begin
				if (I_AVS_BYTEENABLE[0]) ext_reg[7:0] <= I_AVS_WRITEDATA[7:0];
				if (I_AVS_BYTEENABLE[1]) ext_reg[11:8] <= I_AVS_WRITEDATA[11:8];
			end else if (I_AVS_ADDRESS == `REG_DIRECT) begin
				if (I_AVS_BYTEENABLE[0]) direct_reg[7:0] <= I_AVS_WRITEDATA[7:0];
				if (I_AVS_BYTEENABLE[1]) direct_reg[15:8] <= I_AVS_WRITEDATA[15:8];
			end else if (I_AVS_ADDRESS == `REG_TARGET && I_AVS_BYTEENABLE[0]) begin
				disp_reg <= I_AVS_WRITEDATA[7:0];
			end else if (I_AVS_ADDRESS == `REG_INDEXED) begin
				if (I_AVS_BYTEENABLE[0]) base_reg <= I_AVS_WRITEDATA[7:0];
				if (I_AVS_BYTEENABLE[1]) index_reg <= I_AVS_WRITEDATA[15:8];
			end else if (I_AVS_ADDRESS == `REG_OPERANDS) begin
				if (I_AVS_BYTEENABLE[0]) begin
					bit_reg   <= I_AVS_WRITEDATA[2:0];
					pol_reg   <= I_AVS_WRITEDATA[3];
					wpair_reg <= I_AVS_WRITEDATA[7:4];
				end
				if (I_AVS_BYTEENABLE[1]) pair_reg <= I_AVS_WRITEDATA[15:8];
				if (I_AVS_BYTEENABLE[2]) vector_reg <= I_AVS_WRITEDATA[23:16];
				if (I_AVS_BYTEENABLE[3]) imm_reg <= I_AVS_WRITEDATA[31:24];
			end
		end
	end

	// Odd pair addresses are flagged as malformed
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			pair_err_reg <= 1'b0;
		end else begin
			pair_err_reg <= pair_reg[0] | wpair_reg[0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Branch decision and target

	logic [15:0] target_next;
	logic [7:0]  indexed_addr;
	logic [7:0]  bit_mask;
	logic [16:0] target_sum;
	logic [8:0]  indexed_sum;

	// Target wraps within the 16-bit address space
	assign target_sum   = {1'b0, I_NEXT_PC} + {1'b0, {8{disp_reg[7]}}, disp_reg};
	assign target_next  = target_sum[15:0];
	// Signed index wraps within the byte, so the carry is dropped
	assign indexed_sum  = {1'b0, base_reg} + {1'b0, index_reg};
	assign indexed_addr = indexed_sum[7:0];

	// One-hot mask of the selected bit
	for (genvar b = 0; b < 8; b++) begin : g_bit_mask
		assign bit_mask[b] = (bit_reg == 3'(b));
	end

	// Evaluate strobe seen: set by a control write with bit 0 set, cleared when status is read
	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			eval_reg <= 1'b0;
		end else if (wr_acc && I_AVS_ADDRESS == `REG_CTRL && I_AVS_BYTEENABLE[0] && I_AVS_WRITEDATA[0]) begin
			eval_reg <= 1'b1;
		end else if (rd_take && I_AVS_ADDRESS == `REG_STATUS) begin
			eval_reg <= 1'b0;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_BRANCH_TAKEN  <= 1'b0;
			O_BRANCH_TARGET <= `RST_WORD;
		end else begin
			O_BRANCH_TAKEN  <= ctrl_reg[0] & taken_now;
			O_BRANCH_TARGET <= target_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Byte sequencer for register-to-register add

	seq_state_e  state_reg;
	logic        mem_we;
	logic [`MEM_AW-1:0] mem_waddr_reg;
	logic [`MEM_AW-1:0] mem_waddr_next;
	logic [`MEM_AW-1:0] mem_raddr;
	logic [`MEM_AW:0]   waddr_sum;
	logic [`MEM_AW:0]   raddr_sum;
	logic [7:0]  mem_rdata;

	assign mem_we = I_PROG_VALID;

	// Ring pointer wraps, so the carry is dropped
	assign waddr_sum      = {1'b0, mem_waddr_reg} + {{`MEM_AW{1'b0}}, 1'b1};
	assign mem_waddr_next = waddr_sum[`MEM_AW-1:0];
	// Read side always points at the most recently stored byte
	assign raddr_sum      = {1'b0, mem_waddr_reg} + {1'b0, {`MEM_AW{1'b1}}};
	assign mem_raddr      = raddr_sum[`MEM_AW-1:0];

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			mem_waddr_reg <= '0;
		end else if (mem_we) begin
			mem_waddr_reg <= mem_waddr_next;
		end
	end

	opdec_ram u_ram (
		.i_clk   (I_CLK_SYS),
		.i_we    (mem_we),
		.i_waddr (mem_waddr_reg),
		.i_wdata (I_PROG_BYTE),
		.i_raddr (mem_raddr),
		.o_rdata (mem_rdata)
	);

	logic [8:0] dec;
	assign dec = reg_decode(I_PROG_BYTE);

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			state_reg        <= ST_IDLE;
			O_SRC_WORKING    <= 1'b0;
			O_SRC_ADDR       <= `RST_BYTE;
			O_DST_WORKING    <= 1'b0;
			O_DST_ADDR       <= `RST_BYTE;
			O_OPERANDS_VALID <= 1'b0;
		end else begin
			O_OPERANDS_VALID <= 1'b0;
			if (I_PROG_VALID) begin
				case (state_reg)
					ST_IDLE: begin
						if (I_PROG_BYTE == `OPC_ADD_REGS) begin
							state_reg <= ST_SRC;
						end
					end
					ST_SRC: begin
						O_SRC_WORKING <= dec[8];
						O_SRC_ADDR    <= dec[7:0];
						state_reg     <= ST_DST;
					end
					ST_DST: begin
						O_DST_WORKING    <= dec[8];
						O_DST_ADDR       <= dec[7:0];
						O_OPERANDS_VALID <= 1'b1;
						state_reg        <= ST_IDLE;
					end
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data

	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000;
		if (I_AVS_ADDRESS == `REG_CTRL) begin
			rd_mux = {24'h000000, ctrl_reg};
		end else if (I_AVS_ADDRESS == `REG_FLAGS) begin
			rd_mux = {28'h0000000, flags_reg};
		end else if (I_AVS_ADDRESS == `REG_STATUS) begin
			rd_mux = {16'h0000, bit_mask, 5'h00, pair_err_reg, eval_reg, taken_now};
		end else if (I_AVS_ADDRESS == `REG_EXT_ADDR) begin
			rd_mux = {20'h00000, ext_reg};
		end else if (I_AVS_ADDRESS == `REG_DIRECT) begin
			rd_mux = {16'h0000, direct_reg};
		end else if (I_AVS_ADDRESS == `REG_TARGET) begin
			rd_mux = {8'h00, disp_reg, target_next};
		end else if (I_AVS_ADDRESS == `REG_INDEXED) begin
			rd_mux = {8'h00, indexed_addr, index_reg, base_reg};
		end else if (I_AVS_ADDRESS == `REG_OPERANDS) begin
			rd_mux = {imm_reg, vector_reg, pair_reg, wpair_reg, pol_reg, bit_reg};
		end else if (I_AVS_ADDRESS == `REG_SRC_DST) begin
			rd_mux = {14'h0000, O_SRC_WORKING, O_DST_WORKING, O_SRC_ADDR, O_DST_ADDR};
		end else if (I_AVS_ADDRESS == `REG_FETCH) begin
			rd_mux = {16'h0000, mem_rdata, 4'h0, mem_waddr_reg};
		end else begin
			rd_mux = 32'h0000_0000;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (!I_RST_N) begin
			O_AVS_READDATA <= 32'h0000_0000;
		end else if (rd_take) begin
			O_AVS_READDATA <= rd_mux;
		end
	end

endmodule : cond_code_operand_decode

// ---- tb/opdec_prog_mem.sv ----
`timescale 1ns/1ps

module opdec_prog_mem (
	input  wire logic       i_clk,   // System clock
	output logic      [7:0] o_byte,  // Instruction byte
	output logic            o_valid  // Byte valid strobe
);
	logic [7:0] pending [$];

	initial begin
		o_byte = 8'h00;
		o_valid = 1'b0;
	end

	task push(input logic [7:0] b);
		pending.push_back(b);
	endtask : push

	// Idle bus inverts its byte every cycle, so it alternates between the last byte and its inverse
	always @(posedge i_clk) begin
		if (pending.size() > 0) begin
			o_valid <= 1'b1;
			o_byte <= pending.pop_front();
		end else begin
			o_valid <= 1'b0;
			o_byte <= ~o_byte;
		end
	end
endmodule : opdec_prog_mem

// ---- tb/cond_code_operand_decode_sva.sv ----
`timescale 1ns/1ps

module opdec_chk (
	input wire logic        I_CLK_SYS,         // Clock
	input wire logic        I_RST_N,           // Reset
	input wire logic        I_AVS_READ,        // Read
	input wire logic        I_AVS_WRITE,       // Write
	input wire logic [7:0]  I_PROG_BYTE,       // Byte
	input wire logic        I_PROG_VALID,      // Byte valid
	input wire logic [31:0] O_AVS_READDATA,    // Read data
	input wire logic        O_AVS_WAITREQUEST, // Wait
	input wire logic        O_BRANCH_TAKEN,    // Taken
	input wire logic [7:0]  O_SRC_ADDR,        // Source
	input wire logic        O_DST_WORKING,     // Dest working
	input wire logic [7:0]  O_DST_ADDR,        // Dest
	input wire logic        O_OPERANDS_VALID   // Operands valid
);
	default clocking @(posedge I_CLK_SYS); endclocking
	default disable iff (!I_RST_N);
	////////////////////////////////////////
	wait_pulse_a: assert property (!O_AVS_WAITREQUEST |=> O_AVS_WAITREQUEST)
		else $error("waitrequest low too long");
	wait_cause_a: assert property ($fell(O_AVS_WAITREQUEST) |-> $past(I_AVS_READ || I_AVS_WRITE))
		else $error("waitrequest low without request");
	req_answer_a: assert property ((I_AVS_READ || I_AVS_WRITE) && O_AVS_WAITREQUEST |-> ##[1:2] !O_AVS_WAITREQUEST)
		else $error("request not answered");
	rdata_hold_a: assert property (O_AVS_WAITREQUEST && !$past(I_AVS_READ) |-> $stable(O_AVS_READDATA))
		else $error("read data moved without read");
	branch_cause_a: assert property ($changed(O_BRANCH_TAKEN) |->
		$past(I_AVS_WRITE) || $past(I_AVS_WRITE, 2) || $past(I_AVS_WRITE, 3) || $past(I_AVS_WRITE, 4))
		else $error("branch decision changed without write");
	opv_pulse_a: assert property (O_OPERANDS_VALID |-> $past(I_PROG_VALID) ##1 !O_OPERANDS_VALID)
		else $error("operand valid not a pulse after a byte");
	dst_plain_a: assert property (O_OPERANDS_VALID && $past(I_PROG_BYTE[7:4]) != 4'hE |->
		!O_DST_WORKING && O_DST_ADDR == $past(I_PROG_BYTE)) else $error("destination byte not used");
	dst_esc_a: assert property (O_OPERANDS_VALID && $past(I_PROG_BYTE[7:4]) == 4'hE |->
		O_DST_WORKING && O_DST_ADDR == {4'h0, $past(I_PROG_BYTE[3:0])}) else $error("escape not decoded");
	reset_clear_a: assert property (disable iff (1'b0) !I_RST_N |=>
		!O_BRANCH_TAKEN && !O_OPERANDS_VALID && O_AVS_WAITREQUEST && O_SRC_ADDR == 8'h00)
		else $error("state not cleared by reset");
	cover property (O_OPERANDS_VALID);
	cover property (O_BRANCH_TAKEN);
	cover property (I_AVS_READ && !O_AVS_WAITREQUEST);
endmodule : opdec_chk

bind cond_code_operand_decode opdec_chk u_chk (.I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N),
	.I_AVS_READ(I_AVS_READ), .I_AVS_WRITE(I_AVS_WRITE), .I_PROG_BYTE(I_PROG_BYTE),
	.I_PROG_VALID(I_PROG_VALID), .O_AVS_READDATA(O_AVS_READDATA), .O_AVS_WAITREQUEST(O_AVS_WAITREQUEST),
	.O_BRANCH_TAKEN(O_BRANCH_TAKEN), .O_SRC_ADDR(O_SRC_ADDR), .O_DST_WORKING(O_DST_WORKING),
	.O_DST_ADDR(O_DST_ADDR), .O_OPERANDS_VALID(O_OPERANDS_VALID));

// ---- tb/cond_code_operand_decode_tb.sv ----
`timescale 1ns/1ps
`include "opdec_params.svh"

`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin bad_count++; \
	$display("unexpected %s expected %h seen %h", nm, ex, gt); end end

module cond_code_operand_decode_tb
	import opdec_pkg::*;
;
	logic        clk, rst_n, rd, wr, pvalid, waitreq, taken, src_w, dst_w, opv;
	logic [3:0]  addr, be;
	logic [31:0] wdata, rdata, r;
	logic [15:0] next_pc, target;
	byte_t       pbyte, src_a, dst_a;
	int          bad_count, checks_done;
	logic [15:0] tp [3] = '{16'h0010, 16'hFFF0, 16'h1234};
	logic [7:0]  td [3] = '{8'h80, 8'h7F, 8'h00};
	logic [15:0] te [3] = '{16'hFF90, 16'h006F, 16'h1234};
	logic [31:0] xd [3] = '{32'h0000F010, 32'h000005FE, 32'h00007F80};
	logic [7:0]  xe [3] = '{8'h00, 8'h03, 8'hFF};
	logic [3:0]  ra [4] = '{`REG_EXT_ADDR, `REG_DIRECT, `REG_OPERANDS, 4'hF};
	logic [31:0] rv [4] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'h12345678, 32'hFFFFFFFF};
	logic [31:0] re [4] = '{32'h00000FFF, 32'h0000FFFF, 32'h12345678, 32'h00000000};
	logic [31:0] od [3] = '{32'h12345678, 32'hFF00FEE5, 32'h000003E2};
	logic [8:0]  oe [3] = '{9'h101, 9'h020, 9'h104};

	cond_code_operand_decode u_dut (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_AVS_ADDRESS(addr),
		.I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata), .I_AVS_BYTEENABLE(be),
		.I_PROG_BYTE(pbyte), .I_PROG_VALID(pvalid), .I_NEXT_PC(next_pc), .O_AVS_READDATA(rdata),
		.O_AVS_WAITREQUEST(waitreq), .O_BRANCH_TAKEN(taken), .O_BRANCH_TARGET(target),
		.O_SRC_WORKING(src_w), .O_SRC_ADDR(src_a), .O_DST_WORKING(dst_w), .O_DST_ADDR(dst_a),
		.O_OPERANDS_VALID(opv));
	opdec_prog_mem u_mem (.i_clk(clk), .o_byte(pbyte), .o_valid(pvalid));

	always #12.5 clk = ~clk;
	////////////////////////////////////////
	task close_out;
		if (bad_count == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : close_out

	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		addr <= a;
		wdata <= d;
		rd <= !w;
		wr <= w;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (waitreq !== 1'b0 && n < 20);
		r = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
		if (n >= 20) begin
			bad_count++;
			close_out();
		end
	endtask : bus

	function automatic logic cond_exp(input logic [3:0] s, input logic [3:0] f);
		logic b;
		case (s[2:0])
			3'h0: b = 1'b0;
			3'h1: b = f[`FLAG_S] ^ f[`FLAG_V];
			3'h2: b = f[`FLAG_Z] | (f[`FLAG_S] ^ f[`FLAG_V]);
			3'h3: b = f[`FLAG_C] | f[`FLAG_Z];
			3'h4: b = f[`FLAG_V];
			3'h5: b = f[`FLAG_S];
			3'h6: b = f[`FLAG_Z];
			default: b = f[`FLAG_C];
		endcase
		return s[3] ? !b : b;
	endfunction : cond_exp

	function automatic logic [8:0] esc(input byte_t b);
		return (b[7:4] == `ESC_NIBBLE) ? {5'h10, b[3:0]} : {1'b0, b};
	endfunction : esc

	task prog_add(input byte_t s, input byte_t d);
		int n;
		u_mem.push(`OPC_ADD_REGS);
		u_mem.push(s);
		u_mem.push(d);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (opv !== 1'b1 && n < 20);
		if (n >= 20) begin
			bad_count++;
			close_out();
		end
		`CHK("source", esc(s), {src_w, src_a})
		`CHK("destination", esc(d), {dst_w, dst_a})
	endtask : prog_add
	////////////////////////////////////////
	initial begin
		clk = 1'b0;
		rst_n = 1'b0;
		addr = 4'h0;
		be = 4'hF;
		rd = 1'b0;
		wr = 1'b0;
		wdata = 32'h0;
		next_pc = 16'h0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		for (int s = 0; s < 16; s++) begin
			for (int f = 0; f < 16; f++) begin
				bus(1'b1, `REG_FLAGS, f);
				bus(1'b1, `REG_CTRL, {24'h0, s[3:0], 4'h1});
				bus(1'b0, `REG_STATUS, 32'h0);
				`CHK("condition", cond_exp(s[3:0], f[3:0]), r[0])
				`CHK("taken", cond_exp(s[3:0], f[3:0]), taken)
				`CHK("eval seen", 1'b1, r[1])
			end
		end
		bus(1'b1, `REG_CTRL, 32'h80);
		bus(1'b0, `REG_STATUS, 32'h0);
		`CHK("taken disabled", 1'b0, taken)
		`CHK("eval cleared", 1'b0, r[1])
		for (int i = 0; i < 3; i++) begin
			next_pc <= tp[i];
			bus(1'b1, `REG_TARGET, {24'h0, td[i]});
			bus(1'b0, `REG_TARGET, 32'h0);
			`CHK("target", te[i], target)
			`CHK("target read", te[i], r[15:0])
			bus(1'b1, `REG_INDEXED, xd[i]);
			bus(1'b0, `REG_INDEXED, 32'h0);
			`CHK("indexed", xe[i], r[23:16])
			bus(1'b1, `REG_OPERANDS, od[i]);
			bus(1'b0, `REG_STATUS, 32'h0);
			`CHK("pair and bit", oe[i], {r[2], r[15:8]})
		end
		for (int i = 0; i < 4; i++) begin
			bus(1'b1, ra[i], rv[i]);
			bus(1'b0, ra[i], 32'h0);
			`CHK("register", re[i], r)
		end
		be <= 4'h1;
		bus(1'b1, `REG_EXT_ADDR, 32'h00000A55);
		be <= 4'hF;
		bus(1'b0, `REG_EXT_ADDR, 32'h0);
		`CHK("ext lane", 32'h00000F55, r)
		u_mem.push(8'h55);
		prog_add(8'hE8, 8'h43);
		prog_add(8'h08, 8'hE3);
		prog_add(8'hFF, 8'h5A);
		bus(1'b0, `REG_FETCH, 32'h0);
		`CHK("fetch count", 8'h0A, r[7:0])
		`CHK("last byte", 8'h5A, r[15:8])
		bus(1'b1, `REG_CTRL, 32'h81);
		bus(1'b0, `REG_STATUS, 32'h0);
		`CHK("taken always", 1'b1, taken)
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		`CHK("reset state", 19'h20000, {taken, waitreq, opv, src_a, dst_a})
		close_out();
	end
endmodule : cond_code_operand_decode_tb
